// >>> hdl/annp_cfg.svh
// Constants of the next page register bank: offsets, field positions,
// reset values.
// Assumes inclusion by bare name from the package and bench files.
`ifndef ANNP_CFG_SVH
`define ANNP_CFG_SVH

// Register indices as printed; byte address is four times the index.
`define ANNP_IDX_EXP 6'h06
`define ANNP_IDX_TX 6'h07
`define ANNP_IDX_RX 6'h08
`define ANNP_ADDR_EXP {`ANNP_IDX_EXP, 2'h0}
`define ANNP_ADDR_TX {`ANNP_IDX_TX, 2'h0}
`define ANNP_ADDR_RX {`ANNP_IDX_RX, 2'h0}

// Field positions of a page word and of the page-received flag.
`define ANNP_BIT_MORE 15
`define ANNP_BIT_ACK 14
`define ANNP_BIT_MP 13
`define ANNP_BIT_COMPLY_ACKNOWLEDGE 12
`define ANNP_BIT_TOG 11
`define ANNP_CODE_MSB 10
`define ANNP_BIT_PAGE_RX 1

// Reset values.
`define ANNP_MORE_RST 1'h0
`define ANNP_MP_RST 1'h1
`define ANNP_COMPLY_ACKNOWLEDGE_RST 1'h0
`define ANNP_TOG_RST 1'h0
`define ANNP_CODE_RST 11'h001
`define ANNP_PAGE_RST 16'h2001

`endif

// >>> hdl/annp_pkg.sv
// Types shared by the next page register bank.
// Assumes annp_cfg.svh is on the include path.
package annp_pkg;
  `include "annp_cfg.svh"

  // One link code word of a next page exchange.
  typedef struct packed {
    logic more_pages_request;
    logic ack;
    logic message_page_flag;
    logic comply_acknowledge;
    logic page_toggle;
    logic [10:0] code;
  } annp_page_s;

  typedef enum logic [1:0] {
    ANNP_SEL_NONE = 2'h0,
    ANNP_SEL_EXP = 2'h1,
    ANNP_SEL_TX = 2'h2,
    ANNP_SEL_RX = 2'h3
  } annp_sel_e;
endpackage

// >>> hdl/annp_rx_store.sv
// Holder of the page last received from the link partner.
// Assumes a single clock and the bank's asynchronous active-low reset.
`timescale 1ns/100ps
module annp_rx_store
  import annp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input annp_page_s din,
  output annp_page_s dout
);

  typedef struct packed {
    annp_page_s page;
  } annp_store_s;

  annp_store_s st_r;
  annp_store_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.page = din;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= `ANNP_PAGE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.page;
endmodule

// >>> hdl/annp_regs.sv
// Next page transmit and receive registers with the page-received flag,
// reached over APB, facing the auto-negotiation arbitration logic.
// Assumes link-side inputs are synchronous to pclk and pulses last one
// cycle.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module annp_regs
  import annp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic np_active,
  input wire logic base_toggle,
  input wire logic local_ack,
  input wire logic rx_page_valid,
  input annp_page_s rx_page,
  input wire logic tx_page_load,
  output annp_page_s tx_page,
  output logic tx_page_valid
);

  ////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic more_pages_request;
    logic message_page_flag;
    logic comply_acknowledge;
    logic page_toggle;
    logic [10:0] code;
    logic page_rx;
    logic active_d;
    logic [31:0] rdata;
    logic slverr;
    annp_page_s tx_page;
    logic tx_valid;
  } annp_state_s;

  annp_state_s st_r;
  annp_state_s st_nxt;

  annp_page_s rx_held;
  logic rx_load;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic rx_arrive;
  annp_sel_e sel;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Decodes a byte address into one of the mapped registers, or none if unmapped.
  function automatic annp_sel_e decode(input logic [7:0] addr);
    annp_sel_e s;
    s = ANNP_SEL_NONE;
    case (addr)
      `ANNP_ADDR_EXP: begin
        s = ANNP_SEL_EXP;
      end
      `ANNP_ADDR_TX: begin
        s = ANNP_SEL_TX;
      end
      `ANNP_ADDR_RX: begin
        s = ANNP_SEL_RX;
      end
      default: begin
        s = ANNP_SEL_NONE;
      end
    endcase
    return s;
  endfunction

  // Widens a page word to the bus, upper half reading as zero.
  function automatic logic [31:0] widen(input annp_page_s p);
    return {16'h0000, p};
  endfunction

  // Builds the outgoing link code word from the transmit fields.
  function automatic annp_page_s tx_word(input annp_state_s s,
                                         input logic ack);
    annp_page_s p;
    p.more_pages_request = s.more_pages_request;
    p.ack = ack;
    p.message_page_flag = s.message_page_flag;
    p.comply_acknowledge = s.comply_acknowledge;
    p.page_toggle = s.page_toggle;
    p.code = s.code;
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus phases.

  // Zero wait states: every access phase completes at once.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign sel = decode(paddr);
  assign pready = 1'h1;

  ////////////////////////////////////////////////////////////////////////
  // Received page store.

  // Only pages taken during an exchange land here; base pages belong
  // to the partner ability register elsewhere.
  assign rx_arrive = rx_page_valid;
  assign rx_load = rx_page_valid && np_active;

  annp_rx_store u_rx_store (
    .pclk(pclk),
    .presetn(presetn),
    .load(rx_load),
    .din(rx_page),
    .dout(rx_held)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_nxt = st_r;
    st_nxt.active_d = np_active;
    st_nxt.tx_valid = 1'h0;

    // Software writes land at the access edge only.
    if (wr_en && sel == ANNP_SEL_TX) begin
      st_nxt.more_pages_request = pwdata[`ANNP_BIT_MORE];
      st_nxt.message_page_flag = pwdata[`ANNP_BIT_MP];
      st_nxt.comply_acknowledge = pwdata[`ANNP_BIT_COMPLY_ACKNOWLEDGE];
      st_nxt.code = pwdata[`ANNP_CODE_MSB:0];
    end

    // A new exchange starts from the inverse of the base page toggle.
    if (np_active && !st_r.active_d) begin
      st_nxt.page_toggle = ~base_toggle;
    end else if (np_active && tx_page_load) begin
      // The word goes out with the present toggle; the register then
      // shows its inverse for the next one.
      st_nxt.tx_page = tx_word(st_r, local_ack);
      st_nxt.tx_valid = 1'h1;
      st_nxt.page_toggle = ~st_r.page_toggle;
    end

    // Clear on read happens at the access edge; a page arriving in the
    // same cycle keeps the flag set so that it is not lost.
    if (rd_en && sel == ANNP_SEL_EXP) begin
      st_nxt.page_rx = 1'h0;
    end
    if (rx_arrive) begin
      st_nxt.page_rx = 1'h1;
    end

    // Read data and error are prepared in the setup phase so that both
    // come from flip-flops during the access phase.
    if (setup) begin
      st_nxt.slverr = 1'h0;
      case (sel)
        ANNP_SEL_EXP: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[`ANNP_BIT_PAGE_RX] = st_r.page_rx;
        end
        ANNP_SEL_TX: begin
          st_nxt.rdata = widen(tx_word(st_r, local_ack));
        end
        ANNP_SEL_RX: begin
          st_nxt.rdata = widen(rx_held);
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.slverr = 1'h1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.more_pages_request <= `ANNP_MORE_RST;
      st_r.message_page_flag <= `ANNP_MP_RST;
      st_r.comply_acknowledge <= `ANNP_COMPLY_ACKNOWLEDGE_RST;
      st_r.page_toggle <= `ANNP_TOG_RST;
      st_r.code <= `ANNP_CODE_RST;
      st_r.page_rx <= 1'h0;
      st_r.active_d <= 1'h0;
      st_r.rdata <= 32'h0000_0000;
      st_r.slverr <= 1'h0;
      st_r.tx_page <= `ANNP_PAGE_RST;
      st_r.tx_valid <= 1'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Error is shown only while the access phase stands, so a stale
  // flag from a former setup never leaks onto the bus.
  assign prdata = st_r.rdata;
  assign pslverr = access && st_r.slverr;
  assign tx_page = st_r.tx_page;
  assign tx_page_valid = st_r.tx_valid;
endmodule

// >>> testbench/annp_regs_assertions.sv
// Checker for the next page register bank, bound to its ports.
// Assumes the byte map 0x18, 0x1c and 0x20 and zero wait states.
`timescale 1ns/100ps
module annp_regs_assertions
  import annp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic np_active,
  input wire logic tx_page_load,
  input annp_page_s tx_page,
  input wire logic tx_page_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic unmapped;
  assign unmapped = !(paddr inside {8'h18, 8'h1c, 8'h20});
  // The first cycle of an exchange only loads the toggle.
  sequence s_load;
    np_active && $past(np_active) && tx_page_load;
  endsequence
  a_load_valid: assert property (s_load |=> tx_page_valid)
    else $error("load not answered");
  a_valid_cause: assert property
    (tx_page_valid |-> $past(tx_page_load && np_active))
    else $error("valid without load");
  a_toggle_flip: assert property
    (tx_page_valid && $past(tx_page_valid)
     |-> tx_page.page_toggle != $past(tx_page.page_toggle))
    else $error("toggle did not flip");
  a_tx_hold: assert property (!tx_page_valid |-> $stable(tx_page))
    else $error("word changed without load");
  a_ready_high: assert property (pready)
    else $error("ready low");
  a_err_map: assert property (psel && penable |-> pslverr == unmapped)
    else $error("wrong error response");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  a_upper_zero: assert property (prdata[31:16] == 16'h0)
    else $error("upper half not zero");
endmodule
bind annp_regs annp_regs_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .np_active(np_active),
  .tx_page_load(tx_page_load), .tx_page(tx_page),
  .tx_page_valid(tx_page_valid));

// >>> testbench/annp_partner.sv
// Remote link partner: sends one page and fetches two words, the first in the same cycle as the page.
// Assumes the bench pulses send for one cycle.
`timescale 1ns/100ps
module annp_partner
  import annp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input annp_page_s page_in,
  output logic rx_page_valid,
  output annp_page_s rx_page,
  output logic tx_page_load
);
  logic second;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second <= 1'b0;
      rx_page_valid <= 1'b0;
      rx_page <= '0;
      tx_page_load <= 1'b0;
    end else begin
      rx_page_valid <= send;
      // Idle lines change every cycle so no stale word looks valid.
      rx_page <= send ? page_in : ~rx_page;
      tx_page_load <= send || second;
      second <= send;
    end
  end
endmodule

// >>> testbench/annp_regs_tb.sv
// Self-checking bench of the next page register bank over APB.
// Assumes the partner model and the bound checker.
`timescale 1ns/100ps
`include "annp_cfg.svh"
module annp_regs_tb
  import annp_pkg::*;
;
  logic pclk, pready, pslverr, er, rx_page_valid, tx_page_load, tx_page_valid;
  logic presetn = 0, psel = 0, penable = 0, pwrite = 0, send = 0;
  logic np_active = 0, base_toggle = 0, local_ack = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  annp_page_s rx_page, tx_page, sp = '0;
  annp_page_s txq[$];
  int n_mismatch, checked, cyc;
  annp_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .np_active(np_active), .base_toggle(base_toggle), .local_ack(local_ack),
    .rx_page_valid(rx_page_valid), .rx_page(rx_page),
    .tx_page_load(tx_page_load), .tx_page(tx_page),
    .tx_page_valid(tx_page_valid));
  annp_partner u_far (.pclk(pclk), .presetn(presetn), .send(send),
    .page_in(sp), .rx_page_valid(rx_page_valid), .rx_page(rx_page),
    .tx_page_load(tx_page_load));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (tx_page_valid === 1'b1) txq.push_back(tx_page);
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // The wait is bounded at 20 cycles so a dead slave ends the access and prdata is sampled anyway, not a hang.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`ANNP_ADDR_TX, 32'h2001);
    rd(`ANNP_ADDR_RX, 32'h2001);
    rd(`ANNP_ADDR_EXP, 32'h0);
  endtask
  task t_access;
    apb(1'b1, `ANNP_ADDR_TX, 32'hffff_ffff);
    rd(`ANNP_ADDR_TX, 32'hb7ff);
    apb(1'b1, `ANNP_ADDR_TX, 32'h0);
    rd(`ANNP_ADDR_TX, 32'h0);
    apb(1'b1, `ANNP_ADDR_RX, 32'h1234);
    rd(`ANNP_ADDR_RX, 32'h2001);
    rd(8'h3c, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task t_exchange;
    apb(1'b1, `ANNP_ADDR_TX, 32'hd555);
    @(posedge pclk);
    {local_ack, base_toggle, np_active} <= 3'h7;
    repeat (2) @(posedge pclk);
    rd(`ANNP_ADDR_TX, 32'hd555);
    @(posedge pclk);
    send <= 1'b1;
    sp <= 16'h3abc;
    @(posedge pclk);
    send <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'(txq.size()), 32'h2);
    chk({16'h0, txq[0]}, 32'hd555);
    chk({16'h0, txq[1]}, 32'hdd55);
    rd(`ANNP_ADDR_TX, 32'hd555);
    rd(`ANNP_ADDR_RX, 32'h3abc);
    rd(`ANNP_ADDR_EXP, 32'h2);
    rd(`ANNP_ADDR_EXP, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_access;
    t_exchange;
    end_of_test;
  end
endmodule
